// >>> hpp_pkg.sv
// shared constants for the parallel host port
package hpp_pkg;
   localparam int DATA_W = 8;                   // parallel data lanes, bit 0 lsb
   localparam int ADDR_W = 5;                   // register address lanes, bit 0 lsb
   localparam int DAC_W = 10;                   // current dac code width
   localparam int BL_N = 8;                     // fixed-threshold bi-level channels
   localparam int REG_DEPTH = 17;               // implemented byte registers
   localparam int SYNC_W = ADDR_W + DATA_W + 6; // pins passing the synchroniser
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
   localparam logic [DAC_W-1:0] RST_DAC = 10'h000;
   localparam logic [BL_N-1:0] RST_BL = 8'h00;
   localparam logic RST_ACK_N = 1'b1;           // acknowledge idle high
   localparam logic RST_OE_N = 1'b1;            // pins released
   // synchroniser idle image: strobes and selects high, lanes low, so no false select after reset
   localparam logic [SYNC_W-1:0] RST_PINS = 19'h76000;
   // bus ownership, one-hot
   typedef enum logic [2:0] {
      HPP_OWN_PAR = 3'b001,
      HPP_OWN_SPA = 3'b010,
      HPP_OWN_SPB = 3'b100
   } hpp_own_e;
endpackage : hpp_pkg

// >>> hpp_host_port.sv
`timescale 1ns/100ps
// Summary of operation
// RULE_01: eight-bit two-way data bus, bit0 lsb
// RULE_02: even parity over address and data
// RULE_03: parity error drives acknowledge high
// RULE_04: low reset forces all state default
// RULE_05: each bi-level output follows its input
// RULE_06: dac sets current source magnitude when selected
// RULE_07: filter output can be put high-impedance
// RULE_08: five address bits select the register
// RULE_09: port active only with both selects high
// RULE_10: first asserted serial select keeps control
// RULE_11: good parity acknowledges; bad write discarded
module hpp_host_port #(
   parameter int DEPTH = hpp_pkg::REG_DEPTH
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_n_in,                                  // chip select, active low
   input wire logic rd_en_n_in,                               // read enable, active low
   input wire logic wr_en_n_in,                               // write enable, active low
   input wire logic [hpp_pkg::ADDR_W-1:0] host_address_in,
   input wire logic [hpp_pkg::DATA_W-1:0] data_in,
   output logic [hpp_pkg::DATA_W-1:0] data_out,
   output logic data_oe_n_out,                                // low while device drives data
   input wire logic transfer_parity_bit_in,
   output logic transfer_parity_bit_out,
   output logic transfer_parity_bit_oe_n_out,
   output logic ack_n_out,                                    // transfer acknowledge, active low
   input wire logic spi_sel_a_n_in,
   input wire logic spi_sel_b_n_in,
   input wire logic serial_parity_err_in,                     // pulse from serial channels
   output logic spi_a_grant_out,
   output logic spi_b_grant_out,
   input wire logic [hpp_pkg::BL_N-1:0] bilevel_detect_in,
   output logic [hpp_pkg::BL_N-1:0] bilevel_detect_out,
   input wire logic use_dac_in,                               // steer current source from dac
   input wire logic [hpp_pkg::DAC_W-1:0] dac_code_in,
   output logic [hpp_pkg::DAC_W-1:0] dac_drive_out,           // code to complementary dac outputs
   output logic dac_drive_en_out,
   output logic [hpp_pkg::DAC_W-1:0] isrc_mag_out,            // current source magnitude
   input wire logic filter_hiz_in,
   output logic filter_hiz_out,
   output logic wr_strobe_out,                                // one-cycle register write pulse
   output logic [hpp_pkg::ADDR_W-1:0] wr_addr_out,
   output logic [hpp_pkg::DATA_W-1:0] wr_data_out
);
   localparam int SW = hpp_pkg::SYNC_W;

   // synchroniser stages, stage one only feeds stage two
   logic [SW-1:0] pin_s1_q, pin_s2_q;
   logic [hpp_pkg::BL_N-1:0] bl_s1_q, bl_s2_q;
   logic ce_n_s, rd_n_s, wr_n_s, par_s, sa_n_s, sb_n_s;
   logic [hpp_pkg::ADDR_W-1:0] addr_s;
   logic [hpp_pkg::DATA_W-1:0] dat_s;

   hpp_pkg::hpp_own_e own_q, own_d;                // bus ownership
   logic port_act;                                 // parallel port usable
   logic wr_act, rd_act, wr_act_q;                 // strobe levels and history
   logic wr_take, par_ok, wr_fire;
   logic [hpp_pkg::DATA_W-1:0] regs_q [DEPTH];     // register storage
   logic [hpp_pkg::DATA_W-1:0] rd_val;
   logic [hpp_pkg::ADDR_W-1:0] rd_addr_q;          // address of last read driven

   // two flops on every host port and serial select pin before use
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= hpp_pkg::RST_PINS; // idle levels, avoids a false select edge
         pin_s2_q <= hpp_pkg::RST_PINS;
      end else begin
         pin_s1_q <= {ce_n_in, rd_en_n_in, wr_en_n_in, transfer_parity_bit_in, spi_sel_a_n_in,
                      spi_sel_b_n_in, host_address_in, data_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign {ce_n_s, rd_n_s, wr_n_s, par_s, sa_n_s, sb_n_s, addr_s, dat_s} = pin_s2_q;

   // ownership next state, first select asserted keeps it
   always_comb begin
      own_d = own_q;
      unique case (own_q)
         hpp_pkg::HPP_OWN_PAR: begin
            // a wins a same-cycle tie
            if (!sa_n_s) begin
               own_d = hpp_pkg::HPP_OWN_SPA; // see RULE_10
            end else if (!sb_n_s) begin
               own_d = hpp_pkg::HPP_OWN_SPB; // see RULE_10
            end
         end
         hpp_pkg::HPP_OWN_SPA: begin
            if (sa_n_s) begin
               own_d = sb_n_s ? hpp_pkg::HPP_OWN_PAR : hpp_pkg::HPP_OWN_SPB; // see RULE_10
            end
         end
         hpp_pkg::HPP_OWN_SPB: begin
            if (sb_n_s) begin
               own_d = sa_n_s ? hpp_pkg::HPP_OWN_PAR : hpp_pkg::HPP_OWN_SPA; // see RULE_10
            end
         end
         default: begin
            own_d = hpp_pkg::HPP_OWN_PAR; // illegal code recovers
         end
      endcase
   end

   // ownership register and grants
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         own_q <= hpp_pkg::HPP_OWN_PAR; // see RULE_04
         spi_a_grant_out <= 1'b0;
         spi_b_grant_out <= 1'b0;
      end else begin
         own_q <= own_d;
         spi_a_grant_out <= (own_d == hpp_pkg::HPP_OWN_SPA);
         spi_b_grant_out <= (own_d == hpp_pkg::HPP_OWN_SPB);
      end
   end

   // both selects high and nobody holding the bus
   assign port_act = sa_n_s && sb_n_s && (own_q == hpp_pkg::HPP_OWN_PAR); // see RULE_09
   assign wr_act = port_act && !ce_n_s && !wr_n_s;
   assign rd_act = port_act && !ce_n_s && !rd_n_s && wr_n_s; // write wins over read
   assign wr_take = wr_act && !wr_act_q;
   // even parity: address, data and parity bit sum to zero
   assign par_ok = ~^{addr_s, dat_s, par_s}; // see RULE_02
   // addresses beyond the implemented depth are dropped
   assign wr_fire = wr_take && par_ok && (32'(addr_s) < DEPTH); // see RULE_11
   assign rd_val = (32'(addr_s) < DEPTH) ? regs_q[addr_s] : hpp_pkg::RST_DATA; // see RULE_08

   // strobe edge history
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         wr_act_q <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
      end
   end

   // register storage, one entry per implemented address
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_reg
         always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
               regs_q[gi] <= hpp_pkg::RST_DATA; // see RULE_04
            end else if (wr_fire && (32'(addr_s) == gi)) begin
               regs_q[gi] <= dat_s; // see RULE_08
            end
         end
      end
   endgenerate

   // write notice to the rest of the device
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         wr_strobe_out <= 1'b0;
         wr_addr_out <= '0;
         wr_data_out <= hpp_pkg::RST_DATA;
      end else begin
         wr_strobe_out <= wr_fire;
         if (wr_fire) begin
            wr_addr_out <= addr_s;
            wr_data_out <= dat_s;
         end
      end
   end

   // read drive: data and parity together, released when strobe drops
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         data_out <= hpp_pkg::RST_DATA;
         data_oe_n_out <= hpp_pkg::RST_OE_N;
         transfer_parity_bit_out <= 1'b0;
         transfer_parity_bit_oe_n_out <= hpp_pkg::RST_OE_N;
         rd_addr_q <= '0;
      end else begin
         data_oe_n_out <= !rd_act; // see RULE_01
         transfer_parity_bit_oe_n_out <= !rd_act;
         if (rd_act) begin
            data_out <= rd_val; // see RULE_01
            transfer_parity_bit_out <= ^{addr_s, rd_val}; // see RULE_02
            rd_addr_q <= addr_s;
         end
      end
   end

   // acknowledge: low on good transfer, high on any parity error
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ack_n_out <= hpp_pkg::RST_ACK_N;
      end else if (serial_parity_err_in || (wr_take && !par_ok)) begin
         ack_n_out <= 1'b1; // see RULE_03
      end else if (wr_take || rd_act) begin
         ack_n_out <= 1'b0; // see RULE_11
      end else if (!wr_act && !rd_act) begin
         ack_n_out <= hpp_pkg::RST_ACK_N; // idle between transfers
      end
   end

   // bi-level results, resynchronised then registered per channel
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         bl_s1_q <= hpp_pkg::RST_BL;
         bl_s2_q <= hpp_pkg::RST_BL;
         bilevel_detect_out <= hpp_pkg::RST_BL;
      end else begin
         bl_s1_q <= bilevel_detect_in;
         bl_s2_q <= bl_s1_q;
         bilevel_detect_out <= bl_s2_q; // see RULE_05
      end
   end

   // analog-side controls: dac steering and filter release
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         dac_drive_out <= hpp_pkg::RST_DAC;
         dac_drive_en_out <= 1'b0;
         isrc_mag_out <= hpp_pkg::RST_DAC;
         filter_hiz_out <= 1'b0;
      end else begin
         // dac either drives its own outputs or sets the source, never both
         dac_drive_en_out <= !use_dac_in;
         dac_drive_out <= use_dac_in ? hpp_pkg::RST_DAC : dac_code_in;
         isrc_mag_out <= use_dac_in ? dac_code_in : hpp_pkg::RST_DAC; // see RULE_06
         filter_hiz_out <= filter_hiz_in; // see RULE_07
      end
   end

   // checks
   sequence s_bad_write;
      wr_take && !par_ok;
   endsequence
   sequence s_good_write;
      wr_take && par_ok && !serial_parity_err_in;
   endsequence

   chk_ack_parity_err: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_03
      s_bad_write |=> ack_n_out)
      else $error("acknowledge not high after parity error");
   chk_ack_good_xfer: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_11
      s_good_write |=> !ack_n_out)
      else $error("acknowledge not low after good write");
   chk_bad_write_drop: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_11
      s_bad_write |=> !wr_strobe_out)
      else $error("write with bad parity was stored");
   chk_read_parity_even: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_02
      !data_oe_n_out |-> ~^{rd_addr_q, data_out, transfer_parity_bit_out})
      else $error("read parity is not even");
   chk_port_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_09
      (!sa_n_s || !sb_n_s) |=> data_oe_n_out && transfer_parity_bit_oe_n_out)
      else $error("data driven while serial select low");
   chk_bilevel_follow: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_05
      rst_n_in ##1 rst_n_in |-> bilevel_detect_out == $past(bl_s2_q))
      else $error("bi-level output does not follow input");
   chk_isrc_steer: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_06
      use_dac_in |=> isrc_mag_out == $past(dac_code_in) && !dac_drive_en_out)
      else $error("current source not steered by dac");
   chk_filter_hiz: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_07
      filter_hiz_in |=> filter_hiz_out)
      else $error("filter not released to high impedance");
   chk_reset_default: assert property (@(posedge mclk_in) // see RULE_04
      !rst_n_in |=> ack_n_out && data_oe_n_out && !wr_strobe_out)
      else $error("outputs not at default after reset");
   chk_owner_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_10
      (own_q == hpp_pkg::HPP_OWN_SPA) && !sa_n_s |=> spi_a_grant_out && !spi_b_grant_out)
      else $error("first serial select lost control");
   chk_write_store: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see RULE_08
      wr_fire |=> wr_strobe_out && wr_data_out == $past(dat_s) && wr_addr_out == $past(addr_s))
      else $error("write not delivered to addressed register");
endmodule : hpp_host_port

// >>> hpp_host_model.sv
`timescale 1ns/100ps
// host side of the parallel port; host-driven pins move only at the falling edge, lanes echo device data at the rising edge
module hpp_host_model (
   input wire logic mclk_in,
   input wire logic [7:0] dev_data_in,
   input wire logic dev_oe_n_in,
   input wire logic dev_parity_in,
   input wire logic dev_parity_oe_n_in,
   input wire logic ack_n_in,
   output logic ce_n_out,
   output logic rd_en_n_out,
   output logic wr_en_n_out,
   output logic [4:0] host_address_out,
   output logic [7:0] data_out,
   output logic parity_out
);
   logic drv = 1'b0; // host owns the data lanes
   logic [7:0] hd = 8'h00;
   logic hp = 1'b0;
   initial begin
      ce_n_out = 1'b1;
      rd_en_n_out = 1'b1;
      wr_en_n_out = 1'b1;
      host_address_out = 5'h00;
   end
   // released lanes fall to the pull-down level, never the last value
   assign data_out = drv ? hd : (dev_oe_n_in === 1'b0 ? dev_data_in : 8'h00);
   assign parity_out = drv ? hp : (dev_parity_oe_n_in === 1'b0 ? dev_parity_in : 1'b0);
   // write: lanes settle three cycles ahead of the synchroniser, held until acknowledged or eight cycles pass
   task automatic write(input logic [4:0] a, input logic [7:0] d, input logic bad, output logic ok);
      ok = 1'b0;
      host_address_out = a;
      hd = d;
      hp = ^{a, d} ^ bad;
      drv = 1'b1;
      repeat (3) @(negedge mclk_in);
      ce_n_out = 1'b0;
      wr_en_n_out = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge mclk_in);
         ok = (ack_n_in === 1'b0);
      end
      ce_n_out = 1'b1;
      wr_en_n_out = 1'b1;
      drv = 1'b0;
      repeat (5) @(negedge mclk_in); // gap lets acknowledge return high
   endtask : write
   // read: taken once the device turns its drivers on; the caller spaces reads
   task automatic read(input logic [4:0] a, output logic [7:0] d, output logic p, output logic ack);
      host_address_out = a;
      ce_n_out = 1'b0;
      rd_en_n_out = 1'b0;
      d = 8'h00;
      p = 1'b0;
      ack = 1'b1;
      for (int i = 0; i < 8 && ack !== 1'b0; i++) begin
         @(negedge mclk_in);
         if (dev_oe_n_in === 1'b0) begin
            d = data_out;
            p = parity_out;
            ack = ack_n_in;
         end
      end
      ce_n_out = 1'b1;
      rd_en_n_out = 1'b1;
   endtask : read
endmodule : hpp_host_model

// >>> tb_top.sv
`timescale 1ns/100ps
// self-checking bench for the parallel host port
module tb_top;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_n, rd_n, wr_n, par_bus, data_oe_n_out, par_out, par_oe_n, ack_n_out, wr_strobe_out;
   logic [4:0] addr_bus, wr_addr_out, last_a;
   logic [7:0] data_bus, data_out, wr_data_out, last_d, rd_d, bl_out;
   logic spi_sel_a_n_in = 1'b1, spi_sel_b_n_in = 1'b1, serial_parity_err_in = 1'b0;
   logic spi_a_grant_out, spi_b_grant_out, got_ack, rd_par, rd_ack, dac_en, filt_out;
   logic [7:0] bl_in = 8'h00;
   logic use_dac_in = 1'b0, filter_hiz_in = 1'b0;
   logic [9:0] dac_code_in = 10'h000, dac_drive, isrc_mag;
   int err_total = 0, comparisons = 0, cyc = 0, strobes = 0, s_hold = 0;
   logic [7:0] mem [32]; // reference register file, zero past the implemented depth
   hpp_host_port hpp_host_port_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_n_in(ce_n),
      .rd_en_n_in(rd_n), .wr_en_n_in(wr_n), .host_address_in(addr_bus), .data_in(data_bus),
      .data_out(data_out), .data_oe_n_out(data_oe_n_out), .transfer_parity_bit_in(par_bus),
      .transfer_parity_bit_out(par_out), .transfer_parity_bit_oe_n_out(par_oe_n), .ack_n_out(ack_n_out),
      .spi_sel_a_n_in(spi_sel_a_n_in), .spi_sel_b_n_in(spi_sel_b_n_in),
      .serial_parity_err_in(serial_parity_err_in), .spi_a_grant_out(spi_a_grant_out),
      .spi_b_grant_out(spi_b_grant_out), .bilevel_detect_in(bl_in), .bilevel_detect_out(bl_out),
      .use_dac_in(use_dac_in), .dac_code_in(dac_code_in), .dac_drive_out(dac_drive), .dac_drive_en_out(dac_en),
      .isrc_mag_out(isrc_mag), .filter_hiz_in(filter_hiz_in), .filter_hiz_out(filt_out),
      .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));
   hpp_host_model hpp_host_model_inst (.mclk_in(mclk_in), .dev_data_in(data_out), .dev_oe_n_in(data_oe_n_out),
      .dev_parity_in(par_out), .dev_parity_oe_n_in(par_oe_n), .ack_n_in(ack_n_out), .ce_n_out(ce_n),
      .rd_en_n_out(rd_n), .wr_en_n_out(wr_n), .host_address_out(addr_bus), .data_out(data_bus),
      .parity_out(par_bus));
   initial forever #10 mclk_in = ~mclk_in;
   // strobe capture mid-cycle, once the registered outputs have settled
   always @(negedge mclk_in) if (wr_strobe_out === 1'b1) begin
      strobes++;
      last_a = wr_addr_out;
      last_d = wr_data_out;
   end
   // hang guard, well above the roughly eight hundred cycles the run needs
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task results;
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // reset for ten cycles, outputs checked while it is held
   task do_reset;
      rst_n_in = 1'b0;
      repeat (10) @(negedge mclk_in);
      chk({ack_n_out, data_oe_n_out, par_oe_n, wr_strobe_out, spi_a_grant_out, spi_b_grant_out, bl_out}, 16'h3800);
      chk({dac_en, filt_out, isrc_mag}, 16'h0000);
      rst_n_in = 1'b1;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (3) @(negedge mclk_in);
   endtask : do_reset
   task wr(input logic [4:0] a, input logic [7:0] d, input logic bad);
      int s0;
      s0 = strobes;
      hpp_host_model_inst.write(a, d, bad, got_ack);
      chk(got_ack, !bad);
      // unimplemented addresses and bad parity must both leave storage untouched
      chk(16'(strobes - s0), (bad || a >= hpp_pkg::REG_DEPTH) ? 16'h0 : 16'h1);
      if (!bad && a < hpp_pkg::REG_DEPTH) begin
         chk({last_a, last_d}, {a, d});
         mem[a] = d;
      end
   endtask : wr
   task rd(input logic [4:0] a);
      hpp_host_model_inst.read(a, rd_d, rd_par, rd_ack);
      chk(rd_d, mem[a]);
      chk(^{a, rd_d, rd_par}, 1'b0);
      chk(rd_ack, 1'b0);
      repeat (5) @(negedge mclk_in);
   endtask : rd
   task sel(input logic a_n, input logic b_n, input logic [1:0] g);
      spi_sel_a_n_in = a_n;
      spi_sel_b_n_in = b_n;
      repeat (4) @(negedge mclk_in);
      chk({spi_a_grant_out, spi_b_grant_out}, g);
   endtask : sel
   initial begin
      void'($urandom(32'h243ae4f7));
      do_reset();
      for (int a = 0; a < 32; a++) wr(5'(a), 8'($urandom), 1'b0);
      for (int a = 0; a < 4; a++) wr(5'(a), 8'($urandom), 1'b1);
      for (int a = 0; a < 32; a++) rd(5'(a));
      sel(1'b0, 1'b1, 2'b10);
      sel(1'b0, 1'b0, 2'b10);
      s_hold = strobes;
      hpp_host_model_inst.write(5'h02, 8'hc3, 1'b0, got_ack);
      chk(got_ack, 1'b0);
      chk(16'(strobes - s_hold), 16'h0);
      sel(1'b1, 1'b0, 2'b01);
      sel(1'b1, 1'b1, 2'b00);
      sel(1'b0, 1'b0, 2'b10);
      sel(1'b1, 1'b1, 2'b00);
      rd(5'h02);
      // serial parity fault lands while the read acknowledge still stands low
      hpp_host_model_inst.read(5'h01, rd_d, rd_par, rd_ack);
      serial_parity_err_in = 1'b1;
      @(negedge mclk_in);
      serial_parity_err_in = 1'b0;
      chk(ack_n_out, 1'b1);
      repeat (5) @(negedge mclk_in);
      for (int i = 0; i < 8; i++) begin
         bl_in = 8'($urandom);
         use_dac_in = i[0];
         dac_code_in = 10'($urandom);
         filter_hiz_in = i[1];
         repeat (4) @(negedge mclk_in);
         chk(bl_out, bl_in);
         chk(isrc_mag, use_dac_in ? dac_code_in : 10'h000);
         chk({dac_en, dac_drive}, use_dac_in ? 11'h000 : {1'b1, dac_code_in});
         chk(filt_out, filter_hiz_in);
      end
      do_reset();
      for (int a = 0; a < 4; a++) rd(5'(a));
      results();
   end
endmodule : tb_top
